/* src/rx_stat_pkg.sv */
/*
 * constants shared by the receive statistics and fault-status block:
 * histogram bin limits, frame length limits, register map and field layout.
 * assumes a 32-bit AXI4-Lite register bus and frame lengths counted in bytes.
 */
package rx_stat_pkg;

	// ************************************************************
	// frame length limits
	// ************************************************************
	localparam int LEN_W = 16;
	localparam logic [LEN_W-1:0] LEN_DROP_BELOW = 16'h0004;
	localparam logic [LEN_W-1:0] LEN_SMALL_BELOW = 16'h0040;
	localparam int BIN_N = 5;
	// upper histogram bins: 1549-2047, 2048-4095, 4096-8191, 8192-9215, above 9215
	localparam logic [LEN_W-1:0] BIN_LO [BIN_N] = '{16'h060d, 16'h0800, 16'h1000,
		16'h2000, 16'h2400};
	localparam logic [LEN_W-1:0] BIN_HI [BIN_N] = '{16'h07ff, 16'h0fff, 16'h1fff,
		16'h23ff, 16'hffff};

	// ************************************************************
	// link fault sequence detection
	// ************************************************************
	localparam logic [1:0] SEQ_FAULT_COUNT = 2'h3;
	localparam logic [6:0] COL_CLEAR_COUNT = 7'h7f;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam int CTRL_MAX_LEN_LSB = 0;
	localparam int CTRL_CHECK_PRE_BIT = 16;
	localparam int CTRL_CHECK_SFD_BIT = 17;
	localparam int CTRL_TP_CHECK_BIT = 18;
	localparam logic [14:0] MAX_LEN_RESET = 15'h2580;
	localparam int STAT_LOCAL_BIT = 0;
	localparam int STAT_REMOTE_BIT = 1;
	localparam int STAT_INT_LOCAL_BIT = 2;
	localparam int STAT_RCV_LOCAL_BIT = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FLT_NONE = 2'b00,
		FLT_LOCAL = 2'b01,
		FLT_REMOTE = 2'b10
	} fault_t;

endpackage : rx_stat_pkg

/* src/rx_frame_length_tracker.sv */
/*
 * running byte count of the receive frame in flight with truncation detect.
 * assumes beats from the receive parser on the same clock, sof and eof
 * marking the first and last beat of a frame.
 */
`timescale 1ns/1ps
`default_nettype none

module rx_frame_length_tracker
	import rx_stat_pkg::*;
#(
	parameter int BEAT_BYTES = 8,
	parameter int BYTES_W = $clog2(BEAT_BYTES + 1)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic beat_valid,
	input wire logic beat_sof,
	input wire logic beat_eof,
	input wire logic [BYTES_W-1:0] beat_bytes,
	input wire logic [14:0] max_len,
	output logic frame_done,
	output logic [LEN_W-1:0] frame_len,
	output logic trunc_now
);

	logic [LEN_W-1:0] len_r;
	logic [LEN_W-1:0] len_nxt;
	logic trunc_r;
	logic trunc_nxt;
	logic [LEN_W-1:0] base;
	logic [LEN_W:0] sum;
	logic over;

	// ************************************************************
	// length accumulation, saturating at the counter width
	// ************************************************************
	assign base = beat_sof ? '0 : len_r;
	assign sum = {1'b0, base} + {{(LEN_W + 1 - BYTES_W){1'b0}}, beat_bytes};
	assign frame_len = sum[LEN_W] ? '1 : sum[LEN_W-1:0];
	assign over = frame_len > {1'b0, max_len};
	assign trunc_now = beat_valid && over && !(trunc_r && !beat_sof);
	assign frame_done = beat_valid && beat_eof;
	assign len_nxt = beat_valid ? frame_len : len_r;
	assign trunc_nxt = beat_valid ? (over && !beat_eof) : trunc_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			len_r <= '0;
			trunc_r <= 1'b0;
		end else begin
			len_r <= len_nxt;
			trunc_r <= trunc_nxt;
		end
	end

endmodule : rx_frame_length_tracker

`default_nettype wire

/* src/rx_statistics_fault_status.sv */
/*
 * receive statistics increments and fault status of a 10/25 Gb/s mac with pcs.
 * assumes the receive parser, pcs decoder and fcs checker sit on clk and hand
 * over per-cycle events; counters outside add the statistics increment outputs every cycle.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - pulse bins for frames of 1549-2047 and 2048-4095 bytes, good or bad
// - pulse bins for frames of 4096-8191 and 8192-9215 bytes, good or bad
// - two-bit count of frames with wrong check sequence, stomped ones excluded
// - check sequence equal to inverted correct one is stomped, counted separately
// - check sequence indicators last one cycle per event, back to back allowed
// - pulse for frames from 64 bytes to maximum length with wrong check sequence
// - bad preamble indicator fires whatever the preamble check setting
// - bad delimiter indicator fires whatever the delimiter check setting
// - signal ordered-set indicator goes high when such a word arrives
// - two-bit test pattern mismatch count while checking enabled, else zero
// - truncate frame past 15-bit maximum length, one-cycle truncation pulse
// - local fault level is internal or received local fault
// - remote fault level follows detected remote fault condition
// - internal local fault while pattern generation, alignment loss or high ber
// - received local fault from link fault sequence detection while it lasts
// - flag each received block with a valid control code
// - pulse catch-all bin for frames above 9215 bytes
// - frames under 4 bytes dropped, under 64 bytes counted as small
module rx_statistics_fault_status
	import rx_stat_pkg::*;
#(
	parameter int BEAT_BYTES = 8,
	parameter int BYTES_W = $clog2(BEAT_BYTES + 1)
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic rx_beat_valid,
	input wire logic rx_beat_sof,
	input wire logic rx_beat_eof,
	input wire logic [BYTES_W-1:0] rx_beat_bytes,
	input wire logic [31:0] rx_fcs_received,
	input wire logic [31:0] rx_fcs_computed,
	input wire logic rx_preamble_bad,
	input wire logic rx_sfd_bad,
	input wire logic rx_signal_os_word,
	input wire logic [1:0] rx_tp_mismatch,
	input wire logic rx_ctrl_block_valid,
	input wire logic rx_seq_valid,
	input wire logic rx_seq_remote,
	input wire logic tp_gen_active,
	input wire logic lane_align_lost,
	input wire logic hi_ber,
	output logic check_preamble_en,
	output logic check_sfd_en,
	output logic rx_truncate,
	output logic rx_truncated,
	output logic rx_packet_small,
	output logic [1:0] rx_packet_small_cnt,
	output logic rx_packet_1549_2047,
	output logic rx_packet_2048_4095,
	output logic rx_packet_4096_8191,
	output logic rx_packet_8192_9215,
	output logic rx_packet_large,
	output logic [1:0] rx_bad_fcs,
	output logic [1:0] rx_stomped_fcs,
	output logic rx_packet_bad_fcs,
	output logic rx_bad_preamble,
	output logic rx_bad_sfd,
	output logic rx_signal_ordered_set_seen,
	output logic [1:0] rx_test_pattern_mismatch,
	output logic rx_local_fault,
	output logic rx_remote_fault,
	output logic rx_internal_local_fault,
	output logic rx_received_local_fault,
	output logic rx_valid_ctrl_code
);

	// ************************************************************
	// decoding helpers
	// ************************************************************
	function automatic logic in_range(input logic [LEN_W-1:0] v,
		input logic [LEN_W-1:0] lo, input logic [LEN_W-1:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic [1:0] to_cnt(input logic ev);
		to_cnt = {1'b0, ev};
	endfunction : to_cnt

	// ************************************************************
	// register bus
	// ************************************************************
	logic [14:0] max_len_r;
	logic chk_pre_r;
	logic chk_sfd_r;
	logic tp_chk_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic rd_take;
	logic wr_ctrl;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [14:0] max_len_nxt;

	assign aw_take = s_axi_awvalid && !aw_held_r;
	assign w_take = s_axi_wvalid && !w_held_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_ctrl = wr_fire && (aw_addr_r == ADDR_CTRL);
	assign rd_take = s_axi_arvalid && !rvalid_r;
	assign ctrl_word = {13'h0000, tp_chk_r, chk_sfd_r, chk_pre_r, 1'b0, max_len_r};
	assign status_word = {28'h0000000, rx_received_local_fault, rx_internal_local_fault,
		rx_remote_fault, rx_local_fault};
	assign rd_hit = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_STATUS);
	assign rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl_word :
		(s_axi_araddr == ADDR_STATUS) ? status_word : 32'h00000000;
	assign max_len_nxt = {w_strb_r[1] ? w_data_r[14:8] : max_len_r[14:8],
		w_strb_r[0] ? w_data_r[7:0] : max_len_r[7:0]};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			max_len_r <= MAX_LEN_RESET;
			chk_pre_r <= 1'b0;
			chk_sfd_r <= 1'b0;
			tp_chk_r <= 1'b0;
		end else if (wr_ctrl) begin
			max_len_r <= max_len_nxt;
			if (w_strb_r[2]) begin
				chk_pre_r <= w_data_r[CTRL_CHECK_PRE_BIT];
				chk_sfd_r <= w_data_r[CTRL_CHECK_SFD_BIT];
				tp_chk_r <= w_data_r[CTRL_TP_CHECK_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else begin
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= (aw_addr_r == ADDR_CTRL) || (aw_addr_r == ADDR_STATUS) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_word;
				rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign check_preamble_en = chk_pre_r;
	assign check_sfd_en = chk_sfd_r;

	// ************************************************************
	// frame length and classification
	// ************************************************************
	logic frame_done;
	logic [LEN_W-1:0] frame_len;
	logic trunc_now;
	logic frame_kept;
	logic fcs_wrong;
	logic fcs_stomped;
	logic [BIN_N-1:0] bin_hit;

	rx_frame_length_tracker #(
		.BEAT_BYTES(BEAT_BYTES),
		.BYTES_W(BYTES_W)
	) u_len (
		.clk(clk),
		.nrst(nrst),
		.beat_valid(rx_beat_valid),
		.beat_sof(rx_beat_sof),
		.beat_eof(rx_beat_eof),
		.beat_bytes(rx_beat_bytes),
		.max_len(max_len_r),
		.frame_done(frame_done),
		.frame_len(frame_len),
		.trunc_now(trunc_now)
	);

	assign frame_kept = frame_done && (frame_len >= LEN_DROP_BELOW);
	assign fcs_wrong = rx_fcs_received != rx_fcs_computed;
	assign fcs_stomped = rx_fcs_received == ~rx_fcs_computed;

	genvar gi;
	generate
		for (gi = 0; gi < BIN_N; gi++) begin : g_bin
			assign bin_hit[gi] = frame_kept && in_range(frame_len, BIN_LO[gi], BIN_HI[gi]);
		end
	endgenerate

	// ************************************************************
	// per-cycle increments
	// ************************************************************
	logic [BIN_N-1:0] bin_r;
	logic small_r;
	logic [1:0] bad_fcs_r;
	logic [1:0] stomped_r;
	logic pkt_bad_fcs_r;
	logic trunc_r;
	logic bad_pre_r;
	logic bad_sfd_r;
	logic sig_os_r;
	logic [1:0] tp_mis_r;
	logic vcc_r;
	logic [1:0] tp_mis_nxt;

	assign tp_mis_nxt = tp_chk_r ? ({1'b0, rx_tp_mismatch[0]} + {1'b0, rx_tp_mismatch[1]}) :
		2'h0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bin_r <= '0;
			small_r <= 1'b0;
			bad_fcs_r <= 2'h0;
			stomped_r <= 2'h0;
			pkt_bad_fcs_r <= 1'b0;
			trunc_r <= 1'b0;
			bad_pre_r <= 1'b0;
			bad_sfd_r <= 1'b0;
			sig_os_r <= 1'b0;
			tp_mis_r <= 2'h0;
			vcc_r <= 1'b0;
		end else begin
			bin_r <= bin_hit;
			small_r <= frame_kept && (frame_len < LEN_SMALL_BELOW);
			bad_fcs_r <= to_cnt(frame_kept && fcs_wrong && !fcs_stomped);
			stomped_r <= to_cnt(frame_kept && fcs_stomped);
			pkt_bad_fcs_r <= frame_kept && fcs_wrong && (frame_len >= LEN_SMALL_BELOW) &&
				(frame_len <= {1'b0, max_len_r});
			trunc_r <= trunc_now;
			bad_pre_r <= rx_preamble_bad;
			bad_sfd_r <= rx_sfd_bad;
			sig_os_r <= rx_signal_os_word;
			tp_mis_r <= tp_mis_nxt;
			vcc_r <= rx_ctrl_block_valid;
		end
	end

	assign rx_packet_1549_2047 = bin_r[0];
	assign rx_packet_2048_4095 = bin_r[1];
	assign rx_packet_4096_8191 = bin_r[2];
	assign rx_packet_8192_9215 = bin_r[3];
	assign rx_packet_large = bin_r[4];
	assign rx_packet_small = small_r;
	assign rx_packet_small_cnt = {1'b0, small_r};
	assign rx_bad_fcs = bad_fcs_r;
	assign rx_stomped_fcs = stomped_r;
	assign rx_packet_bad_fcs = pkt_bad_fcs_r;
	assign rx_truncated = trunc_r;
	assign rx_truncate = trunc_r;
	assign rx_bad_preamble = bad_pre_r;
	assign rx_bad_sfd = bad_sfd_r;
	assign rx_signal_ordered_set_seen = sig_os_r;
	assign rx_test_pattern_mismatch = tp_mis_r;
	assign rx_valid_ctrl_code = vcc_r;

	// ************************************************************
	// link fault sequence detection
	// ************************************************************
	fault_t fault_r;
	fault_t fault_nxt;
	logic last_remote_r;
	logic [1:0] seq_cnt_r;
	logic [1:0] seq_cnt_nxt;
	logic [6:0] col_cnt_r;
	logic [6:0] col_cnt_nxt;
	logic same_seq;
	logic col_expire;

	assign same_seq = (rx_seq_remote == last_remote_r) && (seq_cnt_r != 2'h0);
	assign col_expire = !rx_seq_valid && (col_cnt_r == COL_CLEAR_COUNT);
	assign seq_cnt_nxt = rx_seq_valid ? (same_seq ? ((seq_cnt_r == SEQ_FAULT_COUNT) ?
		seq_cnt_r : seq_cnt_r + 2'h1) : 2'h1) : (col_expire ? 2'h0 : seq_cnt_r);
	assign col_cnt_nxt = rx_seq_valid ? 7'h00 : (col_expire ? col_cnt_r : col_cnt_r + 7'h01);

	always_comb begin
		fault_nxt = fault_r;
		case (fault_r)
			FLT_NONE, FLT_LOCAL, FLT_REMOTE: begin
				if (rx_seq_valid && same_seq && (seq_cnt_r >= SEQ_FAULT_COUNT - 2'h1)) begin
					fault_nxt = rx_seq_remote ? FLT_REMOTE : FLT_LOCAL;
				end else if (col_expire) begin
					fault_nxt = FLT_NONE;
				end
			end
			default: begin
				fault_nxt = FLT_NONE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_r <= FLT_NONE;
			last_remote_r <= 1'b0;
			seq_cnt_r <= 2'h0;
			col_cnt_r <= 7'h00;
		end else begin
			fault_r <= fault_nxt;
			seq_cnt_r <= seq_cnt_nxt;
			col_cnt_r <= col_cnt_nxt;
			if (rx_seq_valid) begin
				last_remote_r <= rx_seq_remote;
			end
		end
	end

	// ************************************************************
	// fault levels
	// ************************************************************
	logic int_lf_r;
	logic rcv_lf_r;
	logic lf_r;
	logic rf_r;
	logic int_lf_nxt;
	logic rcv_lf_nxt;

	assign int_lf_nxt = tp_gen_active || lane_align_lost || hi_ber;
	assign rcv_lf_nxt = fault_nxt == FLT_LOCAL;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			int_lf_r <= 1'b0;
			rcv_lf_r <= 1'b0;
			lf_r <= 1'b0;
			rf_r <= 1'b0;
		end else begin
			int_lf_r <= int_lf_nxt;
			rcv_lf_r <= rcv_lf_nxt;
			lf_r <= int_lf_nxt || rcv_lf_nxt;
			rf_r <= fault_nxt == FLT_REMOTE;
		end
	end

	assign rx_internal_local_fault = int_lf_r;
	assign rx_received_local_fault = rcv_lf_r;
	assign rx_local_fault = lf_r;
	assign rx_remote_fault = rf_r;

endmodule : rx_statistics_fault_status

`default_nettype wire

/* testbench/rx_stat_counters.sv */
/* statistics counters that add the frame, check sequence, truncation and pattern increment outputs of the block each cycle.
 * assumes the block's increment outputs on the same clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module rx_stat_counters (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] ev,
	input wire logic [1:0] bad_fcs,
	input wire logic [1:0] stomped,
	input wire logic [1:0] tp_err,
	output logic [15:0] cnt_r [11]
);
	// ************************************************************
	// accumulators
	// ************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 11; i++) cnt_r[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < 8; i++) cnt_r[i] <= cnt_r[i] + 16'(ev[i]);
			cnt_r[8] <= cnt_r[8] + 16'(bad_fcs);
			cnt_r[9] <= cnt_r[9] + 16'(stomped);
			cnt_r[10] <= cnt_r[10] + 16'(tp_err);
		end
	end
endmodule : rx_stat_counters
`default_nettype wire

/* testbench/rx_statistics_fault_status_monitor.sv */
/* port checker of the receive statistics and fault status block.
 * assumes it is bound to the top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rx_stat_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic rx_beat_valid,
	input wire logic rx_preamble_bad,
	input wire logic rx_sfd_bad,
	input wire logic rx_signal_os_word,
	input wire logic [1:0] rx_tp_mismatch,
	input wire logic rx_ctrl_block_valid,
	input wire logic tp_gen_active,
	input wire logic lane_align_lost,
	input wire logic hi_ber,
	input wire logic rx_truncate,
	input wire logic rx_truncated,
	input wire logic rx_packet_small,
	input wire logic [1:0] rx_packet_small_cnt,
	input wire logic rx_packet_1549_2047,
	input wire logic [1:0] rx_bad_fcs,
	input wire logic [1:0] rx_stomped_fcs,
	input wire logic rx_bad_preamble,
	input wire logic rx_bad_sfd,
	input wire logic rx_signal_ordered_set_seen,
	input wire logic [1:0] rx_test_pattern_mismatch,
	input wire logic rx_local_fault,
	input wire logic rx_remote_fault,
	input wire logic rx_internal_local_fault,
	input wire logic rx_received_local_fault,
	input wire logic rx_valid_ctrl_code
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_run;
		$past(nrst);
	endsequence
	sequence s_no_beat;
		s_run ##0 !$past(rx_beat_valid);
	endsequence
	chk_pre_follow: assert property (s_run |-> rx_bad_preamble == $past(rx_preamble_bad))
		else $error("bad preamble pulse wrong");
	chk_sfd_follow: assert property (s_run |-> rx_bad_sfd == $past(rx_sfd_bad))
		else $error("bad delimiter pulse wrong");
	chk_sos_follow: assert property (s_run |->
		rx_signal_ordered_set_seen == $past(rx_signal_os_word))
		else $error("ordered set flag wrong");
	chk_ctrl_follow: assert property (s_run |->
		rx_valid_ctrl_code == $past(rx_ctrl_block_valid))
		else $error("control code flag wrong");
	chk_tp_bounded: assert property (s_run |->
		rx_test_pattern_mismatch <= 2'($countones($past(rx_tp_mismatch))))
		else $error("pattern mismatch count too high");
	chk_local_or: assert property (rx_local_fault ==
		(rx_internal_local_fault || rx_received_local_fault))
		else $error("local fault not the or of its causes");
	chk_int_fault: assert property (s_run |->
		rx_internal_local_fault == $past(tp_gen_active || lane_align_lost || hi_ber))
		else $error("internal local fault wrong");
	chk_fcs_excl: assert property (!(rx_bad_fcs != 2'h0 && rx_stomped_fcs != 2'h0))
		else $error("stomped frame also counted bad");
	chk_idle_quiet: assert property (s_no_beat |->
		rx_bad_fcs == 2'h0 && rx_stomped_fcs == 2'h0 && !rx_packet_1549_2047)
		else $error("frame pulse without a beat");
	chk_trunc_same: assert property (rx_truncate == rx_truncated)
		else $error("truncation outputs differ");
	chk_small_cnt: assert property (rx_packet_small_cnt == {1'b0, rx_packet_small})
		else $error("small packet count differs from its pulse");
	chk_reset_quiet: assert property (disable iff (1'b0) !nrst |->
		rx_bad_fcs == 2'h0 && !rx_local_fault && !rx_remote_fault && !rx_truncated)
		else $error("outputs not clear in reset");
	chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : rx_stat_monitor
bind rx_statistics_fault_status rx_stat_monitor u_rx_stat_monitor (.*);
`default_nettype wire

/* testbench/tb_top.sv */
/* self-checking testbench of the receive statistics and fault status block.
 * assumes the package, the design, the counter model and the checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_top
	import rx_stat_pkg::*;
;
	localparam logic [31:0] FCS = 32'h5a5a0f0f;
	logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_fcs_received, rx_fcs_computed, rdat;
	logic [3:0] s_axi_wstrb, rx_beat_bytes;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_tp_mismatch, rx_packet_small_cnt, rx_bad_fcs;
	logic [1:0] rx_stomped_fcs, rx_test_pattern_mismatch, resp;
	logic rx_beat_valid, rx_beat_sof, rx_beat_eof, rx_preamble_bad, rx_sfd_bad;
	logic rx_signal_os_word, rx_ctrl_block_valid, rx_seq_valid, rx_seq_remote;
	logic tp_gen_active, lane_align_lost, hi_ber, check_preamble_en, check_sfd_en;
	logic rx_truncate, rx_truncated, rx_packet_small, rx_packet_1549_2047, rx_packet_2048_4095;
	logic rx_packet_4096_8191, rx_packet_8192_9215, rx_packet_large, rx_packet_bad_fcs;
	logic rx_bad_preamble, rx_bad_sfd, rx_signal_ordered_set_seen, rx_local_fault;
	logic rx_remote_fault, rx_internal_local_fault, rx_received_local_fault, rx_valid_ctrl_code;
	logic [15:0] cnt [11];
	int n_errors, samples_checked, cyc, max_len;
	int exp_cnt [11];
	int lo [4] = '{1549, 2048, 4096, 8192};
	int hi [4] = '{2047, 4095, 8191, 9215};
	int lens [14] = '{3, 8, 63, 64, 1548, 1549, 2047, 2048, 4095, 4096, 8191, 8192, 9215, 9216};

	rx_statistics_fault_status u_rx_statistics_fault_status (.*);
	rx_stat_counters u_rx_stat_counters (.clk(clk), .nrst(nrst), .ev({rx_truncated,
		rx_packet_bad_fcs, rx_packet_large, rx_packet_8192_9215, rx_packet_4096_8191,
		rx_packet_2048_4095, rx_packet_1549_2047, rx_packet_small}), .bad_fcs(rx_bad_fcs),
		.stomped(rx_stomped_fcs), .tp_err(rx_test_pattern_mismatch), .cnt_r(cnt));

	// ************************************************************
	// bus and frame tasks
	// ************************************************************
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task idle(input int n);
		repeat (n) begin
			@(posedge clk);
			{rx_beat_valid, rx_beat_sof, rx_beat_eof, rx_preamble_bad, rx_sfd_bad} <= 5'h00;
			{rx_signal_os_word, rx_ctrl_block_valid, rx_tp_mismatch} <= 4'h0;
		end
	endtask : idle
	task send(input int len, input int kind);
		int left;
		left = len;
		if (len >= 4) begin
			if (len < 64) exp_cnt[0]++;
			for (int b = 0; b < 4; b++) if (len >= lo[b] && len <= hi[b]) exp_cnt[b + 1]++;
			if (len > 9215) exp_cnt[5]++;
			if (kind != 0 && len >= 64 && len <= max_len) exp_cnt[6]++;
			if (len > max_len) exp_cnt[7]++;
			if (kind == 1) exp_cnt[8]++;
			if (kind == 2) exp_cnt[9]++;
		end
		while (left > 0) begin
			@(posedge clk);
			rx_beat_valid <= 1'b1;
			rx_beat_sof <= (left == len);
			rx_beat_eof <= (left <= 8);
			rx_beat_bytes <= (left > 8) ? 4'h8 : 4'(left);
			rx_fcs_received <= (kind == 0) ? FCS : (kind == 1) ? FCS ^ 32'h1 : ~FCS;
			left = left - 8;
		end
	endtask : send
	task cmp_counts();
		idle(3);
		for (int i = 0; i < 11; i++) begin
			`CHK("counter", 16'(exp_cnt[i]), cnt[i])
		end
	endtask : cmp_counts
	task test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done

	// ************************************************************
	// clock, timeout and tests
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_fcs_received} = 80'h0;
		{rx_beat_valid, rx_beat_sof, rx_beat_eof, rx_preamble_bad, rx_sfd_bad} = 5'h00;
		{rx_signal_os_word, rx_ctrl_block_valid, rx_tp_mismatch, rx_beat_bytes} = 8'h00;
		{rx_seq_valid, rx_seq_remote, tp_gen_active, lane_align_lost, hi_ber} = 5'h00;
		s_axi_wstrb = 4'hf;
		rx_fcs_computed = FCS;
		max_len = 9600;
		#1 nrst = 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_CTRL);
		`CHK("ctrl reset", 32'h00002580, rdat)
		rd(8'h08);
		`CHK("unmapped resp", RESP_SLVERR, resp)
		wr(ADDR_STATUS, 32'h0000000f);
		`CHK("status write resp", RESP_OKAY, resp)
		$display("register test done");
		foreach (lens[i]) send(lens[i], i % 3);
		send(8, 2);
		send(8, 2);
		send(100, 1);
		cmp_counts();
		$display("histogram test done");
		rx_tp_mismatch <= 2'h3;
		wr(ADDR_CTRL, 32'h00030064);
		max_len = 100;
		`CHK("preamble check on", 1'b1, check_preamble_en)
		`CHK("delimiter check on", 1'b1, check_sfd_en)
		{rx_preamble_bad, rx_sfd_bad, rx_signal_os_word, rx_ctrl_block_valid} <= 4'hf;
		send(101, 1);
		send(100, 1);
		send(200, 0);
		idle(2);
		wr(ADDR_CTRL, 32'h00042580);
		max_len = 9600;
		rx_tp_mismatch <= 2'h3;
		idle(1);
		rx_tp_mismatch <= 2'h2;
		idle(1);
		exp_cnt[10] += 3;
		cmp_counts();
		$display("truncation and pattern test done");
		for (int c = 0; c < 3; c++) begin
			{hi_ber, lane_align_lost, tp_gen_active} <= 3'h1 << c;
			rd(ADDR_STATUS);
			`CHK("internal fault status", 32'h00000005, rdat)
		end
		{hi_ber, lane_align_lost, tp_gen_active} <= 3'h0;
		rx_seq_valid <= 1'b1;
		idle(8);
		rx_seq_valid <= 1'b0;
		rd(ADDR_STATUS);
		`CHK("received fault status", 32'h00000009, rdat)
		idle(140);
		rd(ADDR_STATUS);
		`CHK("fault cleared", 32'h00000000, rdat)
		{rx_seq_valid, rx_seq_remote} <= 2'h3;
		idle(8);
		rx_seq_valid <= 1'b0;
		rd(ADDR_STATUS);
		`CHK("remote fault status", 32'h00000002, rdat)
		nrst <= 1'b0;
		idle(4);
		nrst <= 1'b1;
		rd(ADDR_STATUS);
		`CHK("status after reset", 32'h00000000, rdat)
		$display("fault test done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
